// >>> core/lail_pkg.sv
package lail_pkg;
    // I/O port addresses
    localparam logic [15:0] KBD_DATA_PORT     = 16'h0060;
    localparam logic [15:0] MAILBOX_PORT_LO   = 16'h0062;
    localparam logic [15:0] KBD_CMD_PORT      = 16'h0064;
    localparam logic [15:0] MAILBOX_PORT_HI   = 16'h0066;
    localparam logic [15:0] CLOCK_INDEX_PORT  = 16'h0070;
    localparam logic [15:0] FAST_GATE_PORT    = 16'h0092;
    localparam logic [15:0] SENSE_LOW_PORT    = 16'h04d0;
    localparam logic [15:0] SENSE_HIGH_PORT   = 16'h04d1;
    localparam logic [15:0] IDE_PRI_BASE      = 16'h01f0;
    localparam logic [15:0] IDE_PRI_CTRL      = 16'h03f6;
    localparam logic [15:0] IDE_SEC_BASE      = 16'h0170;
    localparam logic [15:0] IDE_SEC_CTRL      = 16'h0376;
    // Upper 13 bits select an eight-port IDE block
    localparam int          IDE_BLOCK_LSB     = 3;

    // Reset values
    localparam logic [7:0]  FAST_GATE_RESET   = 8'h02;
    localparam logic [7:0]  SENSE_RESET       = 8'h00;
    localparam logic [7:0]  CLOCK_INDEX_RESET = 8'h00;

    // Field layouts
    localparam logic [7:0]  FAST_GATE_MASK    = 8'h03;
    localparam int          A20_ENABLE_BIT    = 1;
    localparam int          FAST_RESET_BIT    = 0;
    localparam int          NMI_MASK_BIT      = 7;
    localparam logic [7:0]  SENSE_LOW_MASK    = 8'hfa;
    localparam logic [7:0]  SENSE_HIGH_MASK   = 8'hde;
    localparam int          KBD_A20_BIT       = 1;

    // Keyboard controller commands
    localparam logic [7:0]  KBD_CMD_WRITE_OUT = 8'hd1;
    localparam logic [7:0]  KBD_CMD_PULSE_RST = 8'hfe;

    // Keyboard command sequence states
    typedef enum logic [1:0] {
        LAIL_SEQ_IDLE = 2'b01,
        LAIL_SEQ_DATA = 2'b10
    } lail_seq_t;
endpackage : lail_pkg

// >>> core/lail_port_logic.sv
`timescale 1ns/10ps

// Summary of operation
// - Keyboard command port accesses go to ISA
// - Fast gate/reset sequences when enabled act
// - Mailbox ports assert ROM select when enabled
// - Fast gate bit 1 zero masks A20 unless the enabled keyboard A20 gate is set
// - Fast gate bit 0 going from 0 to 1 raises warm-reset interrupt
// - Clock index write-only; bit 7 masks NMI
// - Clock index write goes to ISA, latch pulse
// - Last clock index kept as shadow copy
// - Enabled IDE ranges drive IDE, no ISA
// - Low sense register: lines 7,6,5,4,3,1
// - High sense register: lines 15,14,12,11,10,9
// - Sense registers read/write, reset zero
// - Controller level mode overrides sense bits
// - Sense bit set makes line level-sensitive
module lail_port_logic (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // Host I/O cycle
    input  wire logic [15:0] io_addr_i,
    input  wire logic [7:0]  io_wdata_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    output logic      [7:0]  io_rdata_o,
    output logic             io_rd_valid_o,
    // Configuration bits
    input  wire logic        fast_gate_reset_en_i,
    input  wire logic        mailbox_decode_en_i,
    input  wire logic        ide_enable_i,
    input  wire logic [15:0] irq_ctrl_level_mode_i,
    // ISA cycle
    output logic             isa_cycle_o,
    output logic             isa_write_o,
    output logic      [15:0] isa_addr_o,
    output logic      [7:0]  isa_data_o,
    // Side-band outputs
    output logic             keyboard_rom_chip_select_o,
    output logic             clock_chip_addr_latch_o,
    output logic             ide_primary_sel_o,
    output logic             ide_secondary_sel_o,
    output logic             address_bit20_mask_o,
    output logic             warm_reset_event_o,
    output logic             warm_cpu_reset_o,
    output logic             nmi_mask_o,
    output logic      [7:0]  clock_index_shadow_o,
    output logic      [15:0] irq_level_sense_o
);

    logic            access;
    logic            hit_kbd_cmd;
    logic            hit_kbd_data;
    logic            hit_mailbox;
    logic            hit_clock;
    logic            hit_fast_gate;
    logic            hit_sense_lo;
    logic            hit_sense_hi;
    logic            hit_ide_pri;
    logic            hit_ide_sec;
    logic            internal_hit;
    logic [7:0]      fast_gate_reset_control;
    logic [7:0]      irq_sense_select_low;
    logic [7:0]      irq_sense_select_high;
    logic [7:0]      clock_index_select;
    logic            kbd_a20_gate;
    lail_pkg::lail_seq_t seq_state;
    logic [15:0]     sense_lines;

    // Address decode
    assign access        = io_wr_i | io_rd_i;
    assign hit_kbd_cmd   = io_addr_i == lail_pkg::KBD_CMD_PORT;
    assign hit_kbd_data  = io_addr_i == lail_pkg::KBD_DATA_PORT;
    assign hit_mailbox   = (io_addr_i == lail_pkg::MAILBOX_PORT_LO)
                         | (io_addr_i == lail_pkg::MAILBOX_PORT_HI);
    assign hit_clock     = io_addr_i == lail_pkg::CLOCK_INDEX_PORT;
    assign hit_fast_gate = io_addr_i == lail_pkg::FAST_GATE_PORT;
    assign hit_sense_lo  = io_addr_i == lail_pkg::SENSE_LOW_PORT;
    assign hit_sense_hi  = io_addr_i == lail_pkg::SENSE_HIGH_PORT;
    assign hit_ide_pri   = ide_enable_i
        & ((io_addr_i[15:lail_pkg::IDE_BLOCK_LSB]
            == lail_pkg::IDE_PRI_BASE[15:lail_pkg::IDE_BLOCK_LSB])
           | (io_addr_i == lail_pkg::IDE_PRI_CTRL));
    assign hit_ide_sec   = ide_enable_i
        & ((io_addr_i[15:lail_pkg::IDE_BLOCK_LSB]
            == lail_pkg::IDE_SEC_BASE[15:lail_pkg::IDE_BLOCK_LSB])
           | (io_addr_i == lail_pkg::IDE_SEC_CTRL));
    // Clock index reads are not answered here, they fall through to ISA
    assign internal_hit  = hit_fast_gate | hit_sense_lo | hit_sense_hi;

    // Fast gate control register, reserved bits held at zero
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            fast_gate_reset_control <= lail_pkg::FAST_GATE_RESET;
        else if (io_wr_i && hit_fast_gate)
            fast_gate_reset_control <= io_wdata_i & lail_pkg::FAST_GATE_MASK;
    end

    // Warm-reset interrupt only on a 0 to 1 change of bit 0
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            warm_reset_event_o <= 1'b0;
        else
            warm_reset_event_o <= io_wr_i && hit_fast_gate
                && io_wdata_i[lail_pkg::FAST_RESET_BIT]
                && !fast_gate_reset_control[lail_pkg::FAST_RESET_BIT];
    end

    // Keyboard command sequence tracker
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            seq_state <= lail_pkg::LAIL_SEQ_IDLE;
        else if (io_wr_i && fast_gate_reset_en_i)
        begin
            case (seq_state)
                lail_pkg::LAIL_SEQ_IDLE:
                    if (hit_kbd_cmd && io_wdata_i == lail_pkg::KBD_CMD_WRITE_OUT)
                        seq_state <= lail_pkg::LAIL_SEQ_DATA;
                lail_pkg::LAIL_SEQ_DATA:
                    if (hit_kbd_data || hit_kbd_cmd)
                        seq_state <= lail_pkg::LAIL_SEQ_IDLE;
                default:
                    seq_state <= lail_pkg::LAIL_SEQ_IDLE;
            endcase
        end
        else if (!fast_gate_reset_en_i)
            seq_state <= lail_pkg::LAIL_SEQ_IDLE;
    end

    // Keyboard A20 gate from the output-port data write
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            kbd_a20_gate <= 1'b0;
        else if (io_wr_i && fast_gate_reset_en_i && hit_kbd_data
                 && seq_state == lail_pkg::LAIL_SEQ_DATA)
            kbd_a20_gate <= io_wdata_i[lail_pkg::KBD_A20_BIT];
    end

    // Fast keyboard reset command
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            warm_cpu_reset_o <= 1'b0;
        else
            warm_cpu_reset_o <= io_wr_i && fast_gate_reset_en_i && hit_kbd_cmd
                && io_wdata_i == lail_pkg::KBD_CMD_PULSE_RST;
    end

    // A20 mask when neither source opens the gate
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            address_bit20_mask_o <= 1'b0;
        else
            address_bit20_mask_o <= !fast_gate_reset_control[lail_pkg::A20_ENABLE_BIT]
                && !(fast_gate_reset_en_i && kbd_a20_gate);
    end

    // Clock index port and shadow copy
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            clock_index_select <= lail_pkg::CLOCK_INDEX_RESET;
        else if (io_wr_i && hit_clock)
            clock_index_select <= io_wdata_i;
    end
    assign clock_index_shadow_o = clock_index_select;
    assign nmi_mask_o           = clock_index_select[lail_pkg::NMI_MASK_BIT];

    // Address latch strobe for the clock chip
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            clock_chip_addr_latch_o <= 1'b0;
        else
            clock_chip_addr_latch_o <= io_wr_i && hit_clock;
    end

    // Edge/level select registers
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            irq_sense_select_low  <= lail_pkg::SENSE_RESET;
            irq_sense_select_high <= lail_pkg::SENSE_RESET;
        end
        else if (io_wr_i)
        begin
            if (hit_sense_lo)
                irq_sense_select_low <= io_wdata_i & lail_pkg::SENSE_LOW_MASK;
            if (hit_sense_hi)
                irq_sense_select_high <= io_wdata_i & lail_pkg::SENSE_HIGH_MASK;
        end
    end

    // Per-line sense, controller level mode wins
    assign sense_lines = {irq_sense_select_high, irq_sense_select_low};
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            irq_level_sense_o <= 16'h0000;
        else
            irq_level_sense_o <= sense_lines | irq_ctrl_level_mode_i;
    end

    // Read answer for internal registers
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            io_rd_valid_o <= 1'b0;
            io_rdata_o    <= 8'h00;
        end
        else
        begin
            io_rd_valid_o <= io_rd_i && internal_hit && !hit_ide_pri && !hit_ide_sec;
            if (io_rd_i && hit_fast_gate)
                io_rdata_o <= fast_gate_reset_control;
            else if (io_rd_i && hit_sense_lo)
                io_rdata_o <= irq_sense_select_low;
            else if (io_rd_i && hit_sense_hi)
                io_rdata_o <= irq_sense_select_high;
            else
                io_rdata_o <= 8'h00;
        end
    end

    // ISA forwarding of all unclaimed cycles
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            isa_cycle_o <= 1'b0;
            isa_write_o <= 1'b0;
            isa_addr_o  <= 16'h0000;
            isa_data_o  <= 8'h00;
        end
        else
        begin
            isa_cycle_o <= access && !internal_hit
                && !hit_ide_pri && !hit_ide_sec;
            isa_write_o <= io_wr_i;
            if (access)
            begin
                isa_addr_o <= io_addr_i;
                isa_data_o <= io_wdata_i;
            end
        end
    end

    // Mailbox chip select and IDE selects
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            keyboard_rom_chip_select_o <= 1'b0;
            ide_primary_sel_o          <= 1'b0;
            ide_secondary_sel_o        <= 1'b0;
        end
        else
        begin
            keyboard_rom_chip_select_o <= access && hit_mailbox && mailbox_decode_en_i;
            ide_primary_sel_o          <= access && hit_ide_pri;
            ide_secondary_sel_o        <= access && hit_ide_sec;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    kbd_cmd_isa_a: assert property (
        access && hit_kbd_cmd |=> isa_cycle_o && isa_addr_o == lail_pkg::KBD_CMD_PORT)
        else $error("keyboard command access not forwarded");

    kbd_reset_cmd_a: assert property (
        io_wr_i && fast_gate_reset_en_i && hit_kbd_cmd
        && io_wdata_i == lail_pkg::KBD_CMD_PULSE_RST |=> warm_cpu_reset_o)
        else $error("fast reset command ignored");

    mailbox_sel_a: assert property (
        keyboard_rom_chip_select_o |-> $past(mailbox_decode_en_i) && $past(hit_mailbox))
        else $error("mailbox select without enabled decode");

    a20_mask_a: assert property (
        $past(fast_gate_reset_control[lail_pkg::A20_ENABLE_BIT]) |-> !address_bit20_mask_o)
        else $error("A20 masked while gate bit set");

    warm_event_once_a: assert property (
        warm_reset_event_o |-> !$past(fast_gate_reset_control[lail_pkg::FAST_RESET_BIT])
        ##1 !warm_reset_event_o)
        else $error("warm reset event repeated");

    clock_latch_a: assert property (
        io_wr_i && hit_clock |=> clock_chip_addr_latch_o && isa_cycle_o
        && isa_data_o == $past(io_wdata_i) ##1 clock_index_shadow_o == $past(io_wdata_i, 2))
        else $error("clock index write not latched");

    ide_no_isa_a: assert property (
        ide_primary_sel_o || ide_secondary_sel_o |-> !isa_cycle_o)
        else $error("IDE access leaked to ISA");

    sense_reserved_a: assert property (
        (irq_sense_select_low & ~lail_pkg::SENSE_LOW_MASK) == 8'h00
        && (irq_sense_select_high & ~lail_pkg::SENSE_HIGH_MASK) == 8'h00)
        else $error("reserved sense bit set");

    level_override_a: assert property (
        1'b1 |=> (irq_level_sense_o & $past(irq_ctrl_level_mode_i))
        == $past(irq_ctrl_level_mode_i))
        else $error("controller level mode not applied");

    cover_fast_reset_c: cover property (
        io_wr_i && hit_fast_gate && io_wdata_i[0] ##1 warm_reset_event_o);
    cover_gate_seq_c: cover property (
        seq_state == lail_pkg::LAIL_SEQ_DATA ##[1:20] !address_bit20_mask_o);
    cover_ide_c: cover property (ide_primary_sel_o ##[1:20] ide_secondary_sel_o);

endmodule : lail_port_logic

// >>> tb/lail_host_model.sv
`timescale 1ns/10ps

module lail_host_model (
    // Clock
    input  wire logic        sys_clk_i,
    // I/O cycle request
    output logic      [15:0] io_addr_o,
    output logic      [7:0]  io_wdata_o,
    output logic             io_wr_o,
    output logic             io_rd_o,
    // Read answer
    input  wire logic [7:0]  io_rdata_i
);
    // Idle bus at time zero
    initial
    begin
        io_addr_o  = 16'h0000;
        io_wdata_o = 8'h00;
        io_wr_o    = 1'b0;
        io_rd_o    = 1'b0;
    end

    // One byte cycle, answer sampled 1 ns after the taking edge
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d,
                          output logic [7:0] rdata);
        @(posedge sys_clk_i);
        #1;
        io_addr_o  = a;
        io_wdata_o = (a == 16'h0092) ? (d & 8'h03) : d;
        io_wr_o    = wr;
        io_rd_o    = !wr;
        @(posedge sys_clk_i);
        #1;
        rdata      = io_rdata_i;
        io_wr_o    = 1'b0;
        io_rd_o    = 1'b0;
        // Released lines do not keep the old value
        io_addr_o  = ~io_addr_o;
        io_wdata_o = ~io_wdata_o;
    endtask : access
endmodule : lail_host_model

// >>> tb/tb_top.sv
`timescale 1ns/10ps

module tb_top;
    // Stimulus
    logic        sys_clk;
    logic        resetn;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata;
    logic        io_wr;
    logic        io_rd;
    logic        fg_en;
    logic        mb_en;
    logic        ide_en;
    logic [15:0] ctrl_lvl;
    // Design outputs
    logic [7:0]  io_rdata;
    logic        rd_valid;
    logic        isa_cyc;
    logic        isa_wr;
    logic [15:0] isa_addr;
    logic [7:0]  isa_data;
    logic        kbrom_cs;
    logic        latch;
    logic        ide_pri;
    logic        ide_sec;
    logic        a20_mask;
    logic        wr_evt;
    logic        cpu_rst;
    logic        nmi_mask;
    logic [7:0]  shadow;
    logic [15:0] sense;
    // Bench state
    int          n_fail;
    int          total_checks;
    int          cycles;
    logic [7:0]  rd_d;

    // Device under test
    lail_port_logic lail_port_logic_i (
        .sys_clk_i                  (sys_clk),
        .resetn_i                   (resetn),
        .io_addr_i                  (io_addr),
        .io_wdata_i                 (io_wdata),
        .io_wr_i                    (io_wr),
        .io_rd_i                    (io_rd),
        .io_rdata_o                 (io_rdata),
        .io_rd_valid_o              (rd_valid),
        .fast_gate_reset_en_i       (fg_en),
        .mailbox_decode_en_i        (mb_en),
        .ide_enable_i               (ide_en),
        .irq_ctrl_level_mode_i      (ctrl_lvl),
        .isa_cycle_o                (isa_cyc),
        .isa_write_o                (isa_wr),
        .isa_addr_o                 (isa_addr),
        .isa_data_o                 (isa_data),
        .keyboard_rom_chip_select_o (kbrom_cs),
        .clock_chip_addr_latch_o    (latch),
        .ide_primary_sel_o          (ide_pri),
        .ide_secondary_sel_o        (ide_sec),
        .address_bit20_mask_o       (a20_mask),
        .warm_reset_event_o         (wr_evt),
        .warm_cpu_reset_o           (cpu_rst),
        .nmi_mask_o                 (nmi_mask),
        .clock_index_shadow_o       (shadow),
        .irq_level_sense_o          (sense)
    );

    // Host issuing I/O cycles
    lail_host_model lail_host_model_i (
        .sys_clk_i  (sys_clk),
        .io_addr_o  (io_addr),
        .io_wdata_o (io_wdata),
        .io_wr_o    (io_wr),
        .io_rd_o    (io_rd),
        .io_rdata_i (io_rdata)
    );

    // Clock, 100 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        lail_host_model_i.access(1'b1, a, d, rd_d);
    endtask : wr

    task automatic rd(input logic [15:0] a);
        lail_host_model_i.access(1'b0, a, 8'h00, rd_d);
    endtask : rd

    task automatic settle;
        @(posedge sys_clk);
        #1;
    endtask : settle

    // Sense registers: reset, reserved bits, override
    task automatic t_sense;
        rd(16'h04d0);
        chk_bit(rd_valid, 1'b1);
        chk_val(rd_d, 16'h0000);
        rd(16'h04d1);
        chk_val(rd_d, 16'h0000);
        wr(16'h04d0, 8'hff);
        wr(16'h04d1, 8'hff);
        rd(16'h04d0);
        chk_val(rd_d, 16'h00fa);
        rd(16'h04d1);
        chk_val(rd_d, 16'h00de);
        chk_val(sense, 16'hdefa);
        wr(16'h04d0, 8'h00);
        wr(16'h04d1, 8'h00);
        ctrl_lvl = 16'h8201;
        settle();
        chk_val(sense, 16'h8201);
        ctrl_lvl = 16'h0000;
        $display("test sense done");
    endtask : t_sense

    // Port A mask and warm-reset event
    task automatic t_port_a;
        rd(16'h0092);
        chk_val(rd_d, 16'h0002);
        chk_bit(a20_mask, 1'b0);
        wr(16'h0092, 8'h00);
        settle();
        chk_bit(a20_mask, 1'b1);
        wr(16'h0092, 8'h01);
        chk_bit(wr_evt, 1'b1);
        wr(16'h0092, 8'h03);
        chk_bit(wr_evt, 1'b0);
        wr(16'h0092, 8'h02);
        chk_bit(wr_evt, 1'b0);
        wr(16'h0092, 8'h03);
        chk_bit(wr_evt, 1'b1);
        wr(16'h0092, 8'h02);
        settle();
        chk_bit(a20_mask, 1'b0);
        $display("test port_a done");
    endtask : t_port_a

    // Clock index port
    task automatic t_clock_index;
        wr(16'h0070, 8'h85);
        chk_bit(isa_cyc, 1'b1);
        chk_bit(isa_wr, 1'b1);
        chk_bit(latch, 1'b1);
        chk_val(isa_data, 16'h0085);
        chk_val(isa_addr, 16'h0070);
        chk_val(shadow, 16'h0085);
        chk_bit(nmi_mask, 1'b1);
        wr(16'h0070, 8'h0d);
        chk_bit(nmi_mask, 1'b0);
        chk_val(shadow, 16'h000d);
        rd(16'h0070);
        chk_bit(rd_valid, 1'b0);
        chk_bit(latch, 1'b0);
        $display("test clock_index done");
    endtask : t_clock_index

    // Keyboard command and mailbox ports
    task automatic t_keyboard;
        wr(16'h0064, 8'haa);
        chk_bit(isa_cyc, 1'b1);
        chk_val(isa_data, 16'h00aa);
        rd(16'h0064);
        chk_bit(isa_cyc, 1'b1);
        chk_bit(isa_wr, 1'b0);
        wr(16'h0062, 8'h11);
        chk_bit(kbrom_cs, 1'b0);
        mb_en = 1'b1;
        wr(16'h0062, 8'h11);
        chk_bit(kbrom_cs, 1'b1);
        rd(16'h0066);
        chk_bit(kbrom_cs, 1'b1);
        rd(16'h0064);
        chk_bit(kbrom_cs, 1'b0);
        mb_en = 1'b0;
        $display("test keyboard done");
    endtask : t_keyboard

    // Fast gate and warm reset through keyboard writes
    task automatic t_gate;
        fg_en = 1'b1;
        wr(16'h0092, 8'h00);
        wr(16'h0064, 8'hd1);
        wr(16'h0060, 8'h02);
        settle();
        chk_bit(a20_mask, 1'b0);
        wr(16'h0064, 8'hd1);
        wr(16'h0060, 8'h00);
        settle();
        chk_bit(a20_mask, 1'b1);
        wr(16'h0064, 8'hfe);
        chk_bit(cpu_rst, 1'b1);
        fg_en = 1'b0;
        wr(16'h0064, 8'hfe);
        chk_bit(cpu_rst, 1'b0);
        wr(16'h0092, 8'h02);
        $display("test gate done");
    endtask : t_gate

    // IDE ranges, edges of each block
    task automatic t_ide;
        logic [15:0] tab [6] = '{16'h01f0, 16'h01f7, 16'h03f6, 16'h0170, 16'h0177, 16'h0376};
        ide_en = 1'b1;
        foreach (tab[k])
        begin
            rd(tab[k]);
            chk_bit(ide_pri, k < 3);
            chk_bit(ide_sec, k >= 3);
            chk_bit(isa_cyc, 1'b0);
        end
        wr(16'h01f8, 8'h5a);
        chk_bit(isa_cyc, 1'b1);
        ide_en = 1'b0;
        wr(16'h01f0, 8'h5a);
        chk_bit(ide_pri, 1'b0);
        chk_bit(isa_cyc, 1'b1);
        $display("test ide done");
    endtask : t_ide

    // Mid-run reset returns registers to their reset values
    task automatic t_reset;
        wr(16'h04d0, 8'hfa);
        wr(16'h0070, 8'h85);
        wr(16'h0092, 8'h00);
        resetn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        chk_bit(a20_mask, 1'b0);
        chk_val(shadow, 16'h0000);
        chk_bit(nmi_mask, 1'b0);
        rd(16'h04d0);
        chk_val(rd_d, 16'h0000);
        rd(16'h0092);
        chk_val(rd_d, 16'h0002);
        $display("test reset done");
    endtask : t_reset

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // Main sequence
    initial
    begin
        n_fail = 0;
        total_checks = 0;
        cycles = 0;
        resetn = 1'b0;
        fg_en = 1'b0;
        mb_en = 1'b0;
        ide_en = 1'b0;
        ctrl_lvl = 16'h0000;
        repeat (6) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        t_sense();
        t_port_a();
        t_clock_index();
        t_keyboard();
        t_gate();
        t_ide();
        t_reset();
        end_of_test();
    end
endmodule : tb_top
